// >>> core/cvr_defs.svh
// Register offsets, field positions and reset values of the result and trigger block.
// Assumes inclusion by the block's single design module; the package does not include it.
`ifndef CVR_DEFS_SVH
`define CVR_DEFS_SVH
`define CVR_OFF_RES_LOW 12'h000
`define CVR_OFF_RES_HIGH 12'h004
`define CVR_OFF_CTRL_B 12'h008
`define CVR_OFF_PIN_DIS 12'h00C
`define CVR_OFF_CTRL_A 12'h010
`define CVR_OFF_CHAN_SEL 12'h014
`define CVR_OFF_IRQ_STAT 12'h018
`define CVR_OFF_IRQ_MASK 12'h01C
`define CVR_A_ENABLE 7
`define CVR_A_START 6
`define CVR_A_AUTO 5
`define CVR_A_DONE 4
`define CVR_SEL_LEFT 5
`define CVR_SEL_DIFF 4
`define CVR_B_CMP_MUX 6
`define CVR_B_WMASK 8'h47
`define CVR_IRQ_DONE 0
`define CVR_IRQ_LOST 1
`define CVR_RESET_BYTE 8'h00
`endif

// >>> core/cvr_pkg.sv
// Types shared by the result and trigger block.
// Assumes cvr_defs.svh sits beside it.
package cvr_pkg;
	typedef enum logic [2:0] {
		CVR_IDLE = 3'b001,
		CVR_BUSY = 3'b010,
		CVR_HELD = 3'b100
	} cvr_state_t;
	typedef struct packed {
		logic done;
		logic [9:0] value;
	} cvr_result_t;
	typedef struct packed {
		logic start;
		logic abort;
	} cvr_core_cmd_t;
endpackage : cvr_pkg

// >>> core/cvr_regs.sv
// APB register block for converter results, auto-trigger and pin input disables.
// Assumes an analog core that takes start/abort pulses and returns a done pulse with data.
//
// What this block does and what it expects of software and of the core
// [R1] Each completed conversion loads the result pair unless the low read lock is set
// [R2] Differential channels give two's complement results
// [R3] Low read freezes results until high read
// [R4] Justify bit selects left or right packing
// [R5] Left-justified 8-bit users may read high only
// [R6] Otherwise software reads low before high
// [R7] Software writes zero to reserved control bits
// [R8] Trigger source ignored while auto-trigger clear
// [R9] Rising edge of selected flag starts conversion
// [R10] Switching to a set source counts as edge
// [R11] Selecting free running never triggers itself
// [R12] Trigger field decodes to eight sources
// [R13] Disable bits switch off pin input buffers
// [R14] Disabled pins read zero in port input
// [R15] Disable unused digital inputs to save power
// [R16] Auto-trigger enable starts on positive trigger edges
// [R17] Completion flag sets on update, write-one clears
// [R18] Enable powers converter; clearing aborts conversion
// [R19] Results arriving while locked are discarded
`timescale 1ns/1ns
`default_nettype none
`include "cvr_defs.svh"
module cvr_regs
	import cvr_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire cvr_result_t core_result, // Core completion and raw code
	input wire logic [6:0] trig_flags, // Flags of sources 1..7
	input wire logic vector_ack, // Completion interrupt vector taken
	input wire logic [7:0] pin_raw, // Raw analog pin digital levels
	output cvr_core_cmd_t core_cmd, // Start and abort pulses to core
	output logic core_power, // Converter powered
	output logic [7:0] buf_disable, // Input buffer off per pin
	output logic [7:0] pin_in, // Port input value seen by CPU
	output logic irq // Level interrupt
);
	logic [7:0] res_low_reg;
	logic [7:0] res_low_next;
	logic [7:0] res_high_reg;
	logic [7:0] res_high_next;
	logic [7:0] ctrl_a_reg;
	logic [7:0] ctrl_a_next;
	logic [7:0] ctrl_b_reg;
	logic [7:0] ctrl_b_next;
	logic [7:0] chan_sel_reg;
	logic [7:0] chan_sel_next;
	logic [7:0] pin_dis_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_stat_next;
	logic [1:0] irq_mask_reg;
	logic lock_reg;
	logic lock_next;
	logic trig_prev_reg;
	logic start_pend_reg;
	cvr_state_t state_reg;
	cvr_state_t state_next;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	cvr_core_cmd_t cmd_reg;
	logic irq_reg;
	logic [7:0] pin_in_reg;

	// Bus decode
	wire logic setup = psel & ~penable;
	wire logic wr = setup & pwrite;
	wire logic rd = setup & ~pwrite;
	wire logic [7:0] wbyte = pwdata[7:0];
	wire logic hit_low = paddr == `CVR_OFF_RES_LOW;
	wire logic hit_high = paddr == `CVR_OFF_RES_HIGH;
	wire logic hit_b = paddr == `CVR_OFF_CTRL_B;
	wire logic hit_dis = paddr == `CVR_OFF_PIN_DIS;
	wire logic hit_a = paddr == `CVR_OFF_CTRL_A;
	wire logic hit_sel = paddr == `CVR_OFF_CHAN_SEL;
	wire logic hit_stat = paddr == `CVR_OFF_IRQ_STAT;
	wire logic hit_mask = paddr == `CVR_OFF_IRQ_MASK;
	wire logic mapped = hit_low | hit_high | hit_b | hit_dis | hit_a | hit_sel | hit_stat
		| hit_mask;

	// Result formatting
	wire logic [9:0] code = core_result.value; // Core already signs differential codes, see [R2]
	wire logic left = chan_sel_reg[`CVR_SEL_LEFT];
	wire logic [7:0] fmt_high = left ? code[9:2] : {6'h00, code[9:8]}; // see [R4]
	wire logic [7:0] fmt_low = left ? {code[1:0], 6'h00} : code[7:0]; // see [R4]
	wire logic done_evt = core_result.done & (state_reg == CVR_BUSY);
	wire logic load_res = done_evt & ~lock_reg; // see [R1] see [R19]

	// Trigger selection
	wire logic [7:0] src_vec = {trig_flags, ctrl_a_reg[`CVR_A_DONE]};
	wire logic [2:0] src_sel = ctrl_b_reg[2:0];
	wire logic trig_now = (src_sel != 3'h0) & src_vec[src_sel]; // see [R12] see [R11]
	wire logic auto_on = ctrl_a_reg[`CVR_A_AUTO];
	wire logic enabled = ctrl_a_reg[`CVR_A_ENABLE];
	wire logic trig_edge = auto_on & enabled & trig_now & ~trig_prev_reg; // see [R9] see [R10]
	wire logic free_restart = auto_on & (src_sel == 3'h0) & done_evt; // Free running chain
	wire logic sw_start = wr & hit_a & wbyte[`CVR_A_START];
	// Enable as written this cycle: start with enable works, disable wins
	wire logic en_now = (wr & hit_a) ? wbyte[`CVR_A_ENABLE] : enabled;
	wire logic want_start = en_now & (sw_start | trig_edge | free_restart | start_pend_reg);
	wire logic abort = (state_reg == CVR_BUSY) & wr & hit_a & ~wbyte[`CVR_A_ENABLE]; // see [R18]

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CVR_IDLE: if (want_start) state_next = CVR_BUSY; // see [R16] see [R8]
			CVR_BUSY: begin
				if (abort) state_next = CVR_IDLE;
				else if (core_result.done) state_next = CVR_IDLE;
			end
			CVR_HELD: state_next = CVR_IDLE;
		endcase
	end

	always_comb begin
		ctrl_a_next = ctrl_a_reg;
		if (wr & hit_a) begin
			ctrl_a_next[7:5] = wbyte[7:5];
			ctrl_a_next[3:0] = wbyte[3:0];
			if (wbyte[`CVR_A_DONE]) ctrl_a_next[`CVR_A_DONE] = 1'b0; // see [R17]
		end
		if (vector_ack) ctrl_a_next[`CVR_A_DONE] = 1'b0; // see [R17]
		if (done_evt) ctrl_a_next[`CVR_A_DONE] = 1'b1; // Set wins, see [R17]
		ctrl_a_next[`CVR_A_START] = (state_next == CVR_BUSY);
	end

	always_comb begin
		ctrl_b_next = ctrl_b_reg;
		if (wr & hit_b) ctrl_b_next = wbyte & `CVR_B_WMASK; // Reserved stay zero, see [R7]
		chan_sel_next = chan_sel_reg;
		if (wr & hit_sel) chan_sel_next = wbyte;
		res_low_next = load_res ? fmt_low : res_low_reg;
		res_high_next = load_res ? fmt_high : res_high_reg;
		lock_next = lock_reg;
		if (rd & hit_low) lock_next = 1'b1; // see [R3]
		if (rd & hit_high) lock_next = 1'b0; // see [R3]
		irq_stat_next = irq_stat_reg;
		if (wr & hit_stat) irq_stat_next = irq_stat_reg & ~wbyte[1:0];
		if (done_evt) irq_stat_next[`CVR_IRQ_DONE] = 1'b1;
		if (done_evt & lock_reg) irq_stat_next[`CVR_IRQ_LOST] = 1'b1;
	end

	// Read mux
	wire logic [7:0] rd_byte =
		hit_low ? res_low_reg :
		hit_high ? res_high_reg :
		hit_b ? ctrl_b_reg :
		hit_dis ? pin_dis_reg :
		hit_a ? ctrl_a_reg :
		hit_sel ? chan_sel_reg :
		hit_stat ? {6'h00, irq_stat_reg} :
		hit_mask ? {6'h00, irq_mask_reg} : `CVR_RESET_BYTE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= CVR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_reg <= `CVR_RESET_BYTE;
		end else begin
			ctrl_a_reg <= ctrl_a_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_b_reg <= `CVR_RESET_BYTE;
		end else begin
			ctrl_b_reg <= ctrl_b_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_sel_reg <= `CVR_RESET_BYTE;
		end else begin
			chan_sel_reg <= chan_sel_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_low_reg <= `CVR_RESET_BYTE;
		end else begin
			res_low_reg <= res_low_next; // see [R1]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_high_reg <= `CVR_RESET_BYTE;
		end else begin
			res_high_reg <= res_high_next; // see [R1]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_reg <= 1'b0;
		end else begin
			lock_reg <= lock_next; // see [R3]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 2'h0;
		end else begin
			irq_stat_reg <= irq_stat_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_dis_reg <= `CVR_RESET_BYTE;
		end else if (wr & hit_dis) begin
			pin_dis_reg <= wbyte; // see [R13]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= 2'h0;
		end else if (wr & hit_mask) begin
			irq_mask_reg <= wbyte[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_prev_reg <= 1'b0;
		end else begin
			trig_prev_reg <= trig_now; // see [R10]
		end
	end

	// Trigger seen while busy is kept for one later start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_pend_reg <= 1'b0;
		end else begin
			start_pend_reg <= want_start & (state_reg != CVR_IDLE) & ~abort;
		end
	end

	// Bus response, one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup & ~mapped;
			prdata_reg <= rd ? {24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= '0;
		end else begin
			cmd_reg.start <= (state_reg == CVR_IDLE) & want_start;
			cmd_reg.abort <= abort; // see [R18]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// Port input gating, one flop per analog pin
	genvar pin_idx;
	generate
		for (pin_idx = 0; pin_idx < 8; pin_idx++) begin : g_pin_gate
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_in_reg[pin_idx] <= 1'b0;
				end else begin
					pin_in_reg[pin_idx] <= pin_raw[pin_idx] & ~pin_dis_reg[pin_idx]; // see [R14]
				end
			end
		end
	endgenerate

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign core_cmd = cmd_reg;
	assign core_power = ctrl_a_reg[`CVR_A_ENABLE]; // see [R18]
	assign buf_disable = pin_dis_reg; // see [R13]
	assign pin_in = pin_in_reg;
	assign irq = irq_reg;
endmodule : cvr_regs
`default_nettype wire

// >>> verif/cvr_core_model.sv
// Behavioural converter core answering each start after six cycles.
// Assumes one-cycle start and abort pulses.
`timescale 1ns/1ns
`default_nettype none
module cvr_core_model
	import cvr_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire cvr_core_cmd_t cmd, // Start, abort
	input wire logic [9:0] code, // Code to return
	output cvr_result_t res // Done and code
);
	logic [2:0] cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 3'h0;
			res <= '0;
		end else begin
			res.done <= cnt == 3'h1;
			res.value <= (cnt == 3'h1) ? code : ~res.value;
			cnt <= cmd.abort ? 3'h0 : cmd.start ? 3'h6 : cnt - {2'h0, cnt != 3'h0};
		end
	end
endmodule : cvr_core_model
`default_nettype wire

// >>> verif/cvr_regs_monitor.sv
// Port checker for the result and trigger block.
// Assumes binding into cvr_regs.
`timescale 1ns/1ns
`default_nettype none
module cvr_regs_monitor
	import cvr_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Write
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Wdata
	input wire logic [31:0] prdata, // Rdata
	input wire logic pready, // Ready
	input wire logic [7:0] pin_raw, // Pins
	input wire cvr_core_cmd_t core_cmd, // Core pulses
	input wire logic core_power, // Power
	input wire logic [7:0] buf_disable, // Buffers off
	input wire logic [7:0] pin_in // Port input
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic setup = psel && !penable;
	wire logic wr = setup && pwrite;
	a_ready_next: assert property ($past(presetn) |-> pready == $past(setup))
		else $error("ready late");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper bits set");
	a_ctrl_b_rsvd: assert property (pready && $past(paddr) == 12'h008 |->
		prdata[7] == 1'h0 && prdata[5:3] == 3'h0) else $error("reserved set");
	a_disable_write: assert property (wr && paddr == 12'h00C |=>
		buf_disable == $past(pwdata[7:0])) else $error("disable lost");
	a_power_write: assert property (wr && paddr == 12'h010 |=>
		core_power == $past(pwdata[7])) else $error("power wrong");
	a_pin_gate: assert property ($past(presetn) |->
		pin_in == ($past(pin_raw) & ~$past(buf_disable))) else $error("pin wrong");
	a_start_powered: assert property (core_cmd.start |-> core_power)
		else $error("start unpowered");
	a_abort_off: assert property (core_cmd.abort |-> !core_power)
		else $error("abort powered");
endmodule : cvr_regs_monitor
`default_nettype wire

// >>> verif/cvr_regs_tb_top.sv
// Bench for the result and trigger block.
// Assumes package, design and core model compiled first.
`timescale 1ns/1ns
`default_nettype none
module cvr_regs_tb_top
	import cvr_pkg::*;
;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic vector_ack = 1'h0, pready, pslverr, core_power, irq, rerr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [6:0] trig_flags = 7'h00;
	logic [7:0] pin_raw = 8'hFF, buf_disable, pin_in, rdat;
	logic [9:0] code = 10'h000;
	logic [27:0] rows [4] = '{{12'h00C, 8'hA5, 8'hA5}, {12'h008, 8'h47, 8'h47},
		{12'h01C, 8'h03, 8'h03}, {12'h020, 8'h5A, 8'h00}};
	cvr_result_t core_result;
	cvr_core_cmd_t core_cmd;
	int checks = 0, miscompares = 0, starts = 0;
	cvr_regs cvr_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .core_result, .trig_flags, .vector_ack, .pin_raw,
		.core_cmd, .core_power, .buf_disable, .pin_in, .irq);
	cvr_core_model cvr_core_model_inst (.pclk, .presetn, .cmd(core_cmd), .code, .res(core_result));
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (core_cmd.start === 1'h1) starts++;
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata[7:0];
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	task automatic conv(input logic [9:0] c);
		code <= c;
		apb(1'h1, 12'h010, 8'hC0);
		repeat (10) @(posedge pclk);
	endtask : conv
	task automatic count(input logic [7:0] e);
		repeat (12) @(posedge pclk);
		chk(starts[7:0], e);
		starts = 0;
	endtask : count
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (3000) @(posedge pclk);
		miscompares++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		chk(buf_disable, 8'h00);
		foreach (rows[i]) begin
			apb(1'h1, rows[i][27:16], rows[i][15:8]);
			apb(1'h0, rows[i][27:16], 8'h00);
			chk(rdat, rows[i][7:0]);
		end
		chk({7'h00, rerr}, 8'h01);
		chk(pin_in, 8'h5A);
		$display("rows done");
		conv(10'h2A5);
		apb(1'h0, 12'h000, 8'h00);
		chk(rdat, 8'hA5);
		apb(1'h0, 12'h004, 8'h00);
		chk(rdat, 8'h02);
		chk({7'h00, irq}, 8'h01);
		apb(1'h0, 12'h010, 8'h00);
		chk(rdat, 8'h90);
		vector_ack <= 1'h1;
		@(posedge pclk);
		vector_ack <= 1'h0;
		apb(1'h0, 12'h010, 8'h00);
		chk(rdat, 8'h80);
		apb(1'h1, 12'h018, 8'h03);
		chk({7'h00, irq}, 8'h00);
		apb(1'h1, 12'h014, 8'h20);
		conv(10'h2A5);
		apb(1'h0, 12'h000, 8'h00);
		chk(rdat, 8'h40);
		conv(10'h155);
		apb(1'h0, 12'h004, 8'h00);
		chk(rdat, 8'hA9);
		apb(1'h0, 12'h018, 8'h00);
		chk(rdat, 8'h03);
		conv(10'h155);
		apb(1'h0, 12'h004, 8'h00);
		chk(rdat, 8'h55);
		$display("result tests done");
		apb(1'h1, 12'h008, 8'h01);
		apb(1'h1, 12'h010, 8'h80);
		starts = 0;
		trig_flags[0] <= 1'h1;
		count(8'h00);
		trig_flags[0] <= 1'h0;
		apb(1'h1, 12'h010, 8'hA0);
		starts = 0;
		trig_flags[0] <= 1'h1;
		count(8'h01);
		trig_flags <= 7'h02;
		apb(1'h1, 12'h008, 8'h02);
		count(8'h01);
		apb(1'h1, 12'h008, 8'h00);
		count(8'h00);
		apb(1'h1, 12'h018, 8'h03);
		apb(1'h1, 12'h010, 8'hC0);
		apb(1'h1, 12'h010, 8'h00);
		chk({7'h00, core_power}, 8'h00);
		repeat (10) @(posedge pclk);
		apb(1'h0, 12'h018, 8'h00);
		chk(rdat, 8'h00);
		$display("trigger tests done");
		end_of_test();
	end
endmodule : cvr_regs_tb_top
bind cvr_regs cvr_regs_monitor cvr_regs_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pin_raw, .core_cmd, .core_power, .buf_disable, .pin_in);
`default_nettype wire
